//--- pag_port_a.v
// Port A general-purpose pins with alternate pin selection for the timer
// gate, serial transmit/clock, PWM output B and capture/compare output A.
// Assumes one clock, an 8-bit register port with read data one cycle after
// the read strobe, and pads that resolve level from out and active-low enable.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pag_regs.vh"

module pag_port_a #(
  parameter PIN14 = 0,
  parameter NPINS = 6
) (
  input wire mclk,
  input wire rst_n,
  input wire [`PAG_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [NPINS-1:0] port_a_pins_in,
  output reg [NPINS-1:0] port_a_pins_out,
  output reg [NPINS-1:0] port_a_pins_oe_n,
  input wire serial_tx_or_clock,
  input wire serial_tx_or_clock_en,
  input wire pwm_output_b,
  input wire pwm_output_b_en,
  input wire capcomp_output_a,
  input wire capcomp_output_a_en,
  output reg timer_gate_input,
  output reg port_c_pin4_out,
  output reg port_c_pin4_fn_en
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [NPINS-1:0] port_a_direction_r;
  reg [NPINS-1:0] port_a_direction_nxt;
  reg [NPINS-1:0] port_a_output_latch_r;
  reg [NPINS-1:0] port_a_output_latch_nxt;
  reg [NPINS-1:0] port_a_analog_select_r;
  reg [NPINS-1:0] port_a_analog_select_nxt;
  reg [3:0] alt_pin_function_control_r;
  reg [3:0] alt_pin_function_control_nxt;
  reg [7:0] rdata_nxt;

  wire [NPINS-1:0] pins_sync;
  wire [NPINS-1:0] pins_digital;
  wire [3:0] altfn_mask;
  wire timer_gate_pin_select;
  wire serial_tx_clk_pin_select;
  wire pwm_b_pin_select;
  wire capcomp_out_pin_select;

  // ----------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------
  pag_sync2 #(
    .WIDTH(NPINS)
  ) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(port_a_pins_in),
    .sync_out(pins_sync)
  );

  // Input buffer off on analog pins, so every digital consumer sees 0
  assign pins_digital = pins_sync & ~port_a_analog_select_r;

  assign altfn_mask = (PIN14 != 0) ? `PAG_ALTFN_MASK_14P : `PAG_ALTFN_MASK_8P;
  assign timer_gate_pin_select = alt_pin_function_control_r[`PAG_AF_TGATE];
  assign serial_tx_clk_pin_select = alt_pin_function_control_r[`PAG_AF_SERIAL];
  assign pwm_b_pin_select = alt_pin_function_control_r[`PAG_AF_PWM_B];
  assign capcomp_out_pin_select = alt_pin_function_control_r[`PAG_AF_CAPCOMP];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @* begin
    port_a_direction_nxt = port_a_direction_r;
    port_a_output_latch_nxt = port_a_output_latch_r;
    port_a_analog_select_nxt = port_a_analog_select_r;
    alt_pin_function_control_nxt = alt_pin_function_control_r;
    if (reg_wr) begin
      case (reg_addr)
        `PAG_OFF_PINS: begin
          // Whole-byte write: every bit addressed, so the new value replaces all
          port_a_output_latch_nxt = reg_wdata[NPINS-1:0] & `PAG_LATCH_MASK;
        end
        `PAG_OFF_PIN_SET: begin
          // Pins are read back, so an analog pin or a loaded output can
          // corrupt latch bits that were not meant to change
          port_a_output_latch_nxt = (pins_digital | reg_wdata[NPINS-1:0])
                                    & `PAG_LATCH_MASK;
        end
        `PAG_OFF_PIN_CLR: begin
          port_a_output_latch_nxt = (pins_digital & ~reg_wdata[NPINS-1:0])
                                    & `PAG_LATCH_MASK;
        end
        `PAG_OFF_LATCH: begin
          port_a_output_latch_nxt = reg_wdata[NPINS-1:0] & `PAG_LATCH_MASK;
        end
        `PAG_OFF_DIR: begin
          port_a_direction_nxt = reg_wdata[NPINS-1:0] | `PAG_INPUT_ONLY;
        end
        `PAG_OFF_ANALOG: begin
          port_a_analog_select_nxt = reg_wdata[NPINS-1:0] & `PAG_ANALOG_MASK;
        end
        `PAG_OFF_ALTFN: begin
          alt_pin_function_control_nxt = reg_wdata[3:0] & altfn_mask;
        end
        default: begin
          port_a_direction_nxt = port_a_direction_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `PAG_OFF_PINS: begin
          rdata_nxt = {2'b00, pins_digital & `PAG_PORT_MASK};
        end
        `PAG_OFF_LATCH: begin
          rdata_nxt = {2'b00, port_a_output_latch_r};
        end
        `PAG_OFF_DIR: begin
          rdata_nxt = {2'b00, port_a_direction_r | `PAG_INPUT_ONLY};
        end
        `PAG_OFF_ANALOG: begin
          rdata_nxt = {2'b00, port_a_analog_select_r};
        end
        `PAG_OFF_ALTFN: begin
          rdata_nxt = {4'h0, alt_pin_function_control_r};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_direction_r <= `PAG_DIR_RST;
      port_a_output_latch_r <= `PAG_LATCH_RST;
      port_a_analog_select_r <= `PAG_ANALOG_RST;
      alt_pin_function_control_r <= `PAG_ALTFN_RST;
      reg_rdata <= 8'h00;
    end else begin
      port_a_direction_r <= port_a_direction_nxt;
      port_a_output_latch_r <= port_a_output_latch_nxt;
      port_a_analog_select_r <= port_a_analog_select_nxt;
      alt_pin_function_control_r <= alt_pin_function_control_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output data selection
  // ----------------------------------------------------------------
  // Per pin, the first enabled function in priority order wins; the
  // latch only drives when no routed peripheral is enabled there.
  reg [NPINS-1:0] pad_out_nxt;
  reg [NPINS-1:0] pad_oe_n_nxt;
  reg pc4_out_nxt;
  reg pc4_en_nxt;
  reg tx_on_p0;
  reg tx_on_p4;
  reg pwm_on_p0;
  reg pwm_on_p4;
  reg ccp_on_p2;
  reg ccp_on_p5;

  always @* begin
    pad_out_nxt = port_a_output_latch_r;
    pc4_out_nxt = 1'b0;
    pc4_en_nxt = 1'b0;
    tx_on_p0 = 1'b0;
    tx_on_p4 = 1'b0;
    pwm_on_p0 = 1'b0;
    pwm_on_p4 = 1'b0;
    ccp_on_p2 = 1'b0;
    ccp_on_p5 = 1'b0;
    if (PIN14 != 0) begin
      tx_on_p0 = serial_tx_clk_pin_select & serial_tx_or_clock_en;
      // Pin C4 shared by serial and PWM B; serial listed first
      if (!serial_tx_clk_pin_select && serial_tx_or_clock_en) begin
        pc4_out_nxt = serial_tx_or_clock;
        pc4_en_nxt = 1'b1;
      end else if (pwm_output_b_en) begin
        pc4_out_nxt = pwm_output_b;
        pc4_en_nxt = 1'b1;
      end
    end else begin
      tx_on_p0 = ~serial_tx_clk_pin_select & serial_tx_or_clock_en;
      tx_on_p4 = serial_tx_clk_pin_select & serial_tx_or_clock_en;
      pwm_on_p0 = ~pwm_b_pin_select & pwm_output_b_en;
      pwm_on_p4 = pwm_b_pin_select & pwm_output_b_en;
      ccp_on_p2 = ~capcomp_out_pin_select & capcomp_output_a_en;
      ccp_on_p5 = capcomp_out_pin_select & capcomp_output_a_en;
    end
    if (tx_on_p0) begin
      pad_out_nxt[`PAG_PIN0] = serial_tx_or_clock;
    end else if (pwm_on_p0) begin
      pad_out_nxt[`PAG_PIN0] = pwm_output_b;
    end
    if (tx_on_p4) begin
      pad_out_nxt[`PAG_PIN4] = serial_tx_or_clock;
    end else if (pwm_on_p4) begin
      pad_out_nxt[`PAG_PIN4] = pwm_output_b;
    end
    if (ccp_on_p2) begin
      pad_out_nxt[`PAG_PIN2] = capcomp_output_a;
    end
    if (ccp_on_p5) begin
      pad_out_nxt[`PAG_PIN5] = capcomp_output_a;
    end
    pad_out_nxt[`PAG_PIN3] = 1'b0;
    // Driver follows direction only; analog select plays no part here
    pad_oe_n_nxt = port_a_direction_r | `PAG_INPUT_ONLY;
  end

  // ----------------------------------------------------------------
  // Registered pad and peripheral outputs
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_pins_out <= {NPINS{1'b0}};
      port_a_pins_oe_n <= `PAG_DIR_RST;
      port_c_pin4_out <= 1'b0;
      port_c_pin4_fn_en <= 1'b0;
      timer_gate_input <= 1'b0;
    end else begin
      port_a_pins_out <= pad_out_nxt;
      port_a_pins_oe_n <= pad_oe_n_nxt;
      port_c_pin4_out <= pc4_out_nxt;
      port_c_pin4_fn_en <= pc4_en_nxt;
      if (timer_gate_pin_select) begin
        timer_gate_input <= pins_digital[`PAG_PIN3];
      end else begin
        timer_gate_input <= pins_digital[`PAG_PIN4];
      end
    end
  end

endmodule
`default_nettype wire

//--- pag_regs.vh
// Register offsets, field positions and reset values of the port A block.
// Assumes an 8-bit register bus with a 3-bit address; included by bare name.
// Behaviour
// - Gate select: 0 pin 4, 1 pin 3
// - Serial select moves transmit/clock between pins
// - PWM B select: pin 0/4; 14-pin fixed
// - Capture/compare select: pin 2/5, 8-pin only
// - Five bidirectional pins plus input-only pin 3, each with direction
// - Direction 1 disables driver, 0 drives latch
// - Pin 3 input only, direction reads 1
// - Port read gives pins, write hits latch
// - Port set/clear writes are read-modify-write into latch
// - Direction bits still steer analog pins' drivers
// - Analog select forces digital reads to 0
// - Analog select leaves digital outputs untouched
// - Highest priority enabled function owns pin
// - Analog disables input buffer, resets to 1
// - Direction bits reset to 1, all inputs
`ifndef PAG_REGS_VH
`define PAG_REGS_VH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define PAG_ADDR_W 3
`define PAG_OFF_PINS 3'h0
`define PAG_OFF_DIR 3'h1
`define PAG_OFF_LATCH 3'h2
`define PAG_OFF_ANALOG 3'h3
`define PAG_OFF_ALTFN 3'h4
`define PAG_OFF_PIN_SET 3'h5
`define PAG_OFF_PIN_CLR 3'h6

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define PAG_PORT_MASK 6'h3F
`define PAG_LATCH_MASK 6'h37
`define PAG_ANALOG_MASK 6'h17
`define PAG_INPUT_ONLY 6'h08
`define PAG_DIR_RST 6'h3F
`define PAG_LATCH_RST 6'h00
`define PAG_ANALOG_RST 6'h17
`define PAG_ALTFN_RST 4'h0
`define PAG_ALTFN_MASK_8P 4'hF
`define PAG_ALTFN_MASK_14P 4'hC

// ----------------------------------------------------------------
// Alternate pin function control fields
// ----------------------------------------------------------------
`define PAG_AF_CAPCOMP 0
`define PAG_AF_PWM_B 1
`define PAG_AF_SERIAL 2
`define PAG_AF_TGATE 3

// ----------------------------------------------------------------
// Pin numbers
// ----------------------------------------------------------------
`define PAG_PIN0 0
`define PAG_PIN2 2
`define PAG_PIN3 3
`define PAG_PIN4 4
`define PAG_PIN5 5

`endif

//--- pag_sync2.v
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are unrelated to mclk; the first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none

module pag_sync2 #(
  parameter WIDTH = 6
) (
  input wire mclk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

//--- pag_pad_model.sv
// Pad model for the six port A pins.
// Assumes weak pull-ups: a pin that nobody drives floats high.
`timescale 1ns/10ps
`default_nettype none
module pag_pad_model (
  input wire logic [5:0] drv_out,
  input wire logic [5:0] drv_oe_n,
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  output logic [5:0] pin_level
);
  // Block's driver wins; an outside source only shows on a released pin
  assign pin_level = (~drv_oe_n & drv_out) | (drv_oe_n & ext_en & ext_val) | (drv_oe_n & ~ext_en);
endmodule
`default_nettype wire

//--- pag_port_a_checker.sv
// Checker for the port A block, bound to every pag_port_a.
// PIN14 follows the bound instance; mirrors the analog register, and the select register without the 14-pin mask.
`timescale 1ns/10ps
`default_nettype none
module pag_port_a_checker #(
  parameter PIN14 = 0
) (
  input wire mclk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [5:0] port_a_pins_in,
  input wire [5:0] port_a_pins_out,
  input wire [5:0] port_a_pins_oe_n,
  input wire serial_tx_or_clock,
  input wire serial_tx_or_clock_en,
  input wire pwm_output_b,
  input wire pwm_output_b_en,
  input wire capcomp_output_a_en,
  input wire timer_gate_input,
  input wire port_c_pin4_out,
  input wire port_c_pin4_fn_en
);
  reg [3:0] sel_r;
  reg [5:0] ana_r;
  wire any_en = serial_tx_or_clock_en | pwm_output_b_en | capcomp_output_a_en;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 4'h0;
      ana_r <= 6'h17;
    end else if (reg_wr && reg_addr == 3'h4) begin
      sel_r <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == 3'h3) begin
      ana_r <= reg_wdata[5:0] & 6'h17;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_in3;
    port_a_pins_oe_n[3];
  endproperty
  a_in3: assert property (p_in3) else $error("pin 3 driven");
  property p_dir_drv;
    reg_wr && reg_addr == 3'h1 |-> ##2
      {2'h0, port_a_pins_oe_n} == (($past(reg_wdata, 2) & 8'h3F) | 8'h08);
  endproperty
  a_dir_drv: assert property (p_dir_drv) else $error("driver enable wrong");
  property p_lat_drv;
    reg_wr && reg_addr == 3'h0 && !any_en ##1 (!reg_wr && !any_en) [*2]
      |-> {2'h0, port_a_pins_out} == ($past(reg_wdata, 2) & 8'h37);
  endproperty
  a_lat_drv: assert property (p_lat_drv) else $error("latch not driven");
  property p_dir_rd;
    reg_rd && reg_addr == 3'h1 |=> reg_rdata[3] && reg_rdata[7:6] == 2'h0;
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");
  property p_pin_rd;
    ($stable(port_a_pins_in) && $stable(ana_r)) [*4] ##0 (reg_rd && reg_addr == 3'h0)
      |=> reg_rdata == {2'h0, $past(port_a_pins_in) & ~ana_r};
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong");
  property p_gate;
    ($stable(port_a_pins_in) && $stable(ana_r) && $stable(sel_r)) [*4] |->
      timer_gate_input == (sel_r[3] ? port_a_pins_in[3] : port_a_pins_in[4] & !ana_r[4]);
  endproperty
  a_gate: assert property (p_gate) else $error("gate pin wrong");
  property p_ser0;
    serial_tx_or_clock_en && (sel_r[2] == (PIN14 != 0)) |=>
      port_a_pins_out[0] == $past(serial_tx_or_clock);
  endproperty
  a_ser0: assert property (p_ser0) else $error("serial not on pin 0");
  property p_c4_pwm;
    pwm_output_b_en && !serial_tx_or_clock_en |=> port_c_pin4_fn_en == (PIN14 != 0)
      && port_c_pin4_out == ((PIN14 != 0) && $past(pwm_output_b));
  endproperty
  a_c4_pwm: assert property (p_c4_pwm) else $error("pwm B port C pin wrong");
  c_ser4: cover property (serial_tx_or_clock_en && sel_r[2]);
  c_pin_rd: cover property (reg_rd && reg_addr == 3'h0 && ana_r == 6'h00);
  c_gate3: cover property (sel_r[3] && timer_gate_input);
endmodule
bind pag_port_a pag_port_a_checker #(.PIN14(PIN14)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_a_pins_in(port_a_pins_in), .port_a_pins_out(port_a_pins_out),
  .port_a_pins_oe_n(port_a_pins_oe_n), .serial_tx_or_clock(serial_tx_or_clock),
  .serial_tx_or_clock_en(serial_tx_or_clock_en), .pwm_output_b(pwm_output_b),
  .pwm_output_b_en(pwm_output_b_en), .capcomp_output_a_en(capcomp_output_a_en),
  .timer_gate_input(timer_gate_input), .port_c_pin4_out(port_c_pin4_out),
  .port_c_pin4_fn_en(port_c_pin4_fn_en));
`default_nettype wire

//--- pag_port_a_bench.sv
// Self-checking bench for the port A block; the 14-pin variant runs beside it.
// Assumes the pad model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module pag_port_a_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] ra = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ser = 1'b0, ser_en = 1'b0, pwm = 1'b0, pwm_en = 1'b0, cc = 1'b0, cc_en = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [5:0] ee = 6'h00;
  wire [7:0] rdata;
  wire [5:0] pins, pout, poe_n;
  wire tg, c4, c4_en;
  wire [7:0] rdata14;
  wire [5:0] pout14;
  wire c4_14, c4en14;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] d;
  // Address, write data, read-back
  logic [18:0] rows [7] = '{{3'h1, 8'h00, 8'h08}, {3'h1, 8'hFF, 8'h3F}, {3'h2, 8'hFF, 8'h37},
    {3'h3, 8'hFF, 8'h17}, {3'h3, 8'h00, 8'h00}, {3'h4, 8'hFF, 8'h0F}, {3'h7, 8'hFF, 8'h00}};
  always #50 mclk = ~mclk;
  pag_port_a #(.PIN14(0), .NPINS(6)) u_pag_port_a (.mclk(mclk), .rst_n(rst_n), .reg_addr(ra),
    .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .port_a_pins_in(pins),
    .port_a_pins_out(pout), .port_a_pins_oe_n(poe_n), .serial_tx_or_clock(ser),
    .serial_tx_or_clock_en(ser_en), .pwm_output_b(pwm), .pwm_output_b_en(pwm_en),
    .capcomp_output_a(cc), .capcomp_output_a_en(cc_en), .timer_gate_input(tg),
    .port_c_pin4_out(c4), .port_c_pin4_fn_en(c4_en));
  pag_pad_model u_pag_pad_model (.drv_out(pout), .drv_oe_n(poe_n), .ext_val(ev),
    .ext_en(ee), .pin_level(pins));
  // 14-pin variant shares bus and pins; only its outputs are compared
  pag_port_a #(.PIN14(1), .NPINS(6)) u_pag_port_a_p14 (.mclk(mclk), .rst_n(rst_n), .reg_addr(ra),
    .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata14), .port_a_pins_in(pins),
    .port_a_pins_out(pout14), .port_a_pins_oe_n(), .serial_tx_or_clock(ser),
    .serial_tx_or_clock_en(ser_en), .pwm_output_b(pwm), .pwm_output_b_en(pwm_en),
    .capcomp_output_a(cc), .capcomp_output_a_en(cc_en), .timer_gate_input(),
    .port_c_pin4_out(c4_14), .port_c_pin4_fn_en(c4en14));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle after each write keeps strobe edges apart
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    wr_s <= 1'b1;
    ra <= a;
    wd <= v;
    @(posedge mclk);
    wr_s <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    rd_s <= 1'b1;
    ra <= a;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(posedge mclk);
    chk(rdata, exp);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({2'h0, poe_n}, 8'h3F);
    rdchk(3'h1, 8'h3F);
    rdchk(3'h3, 8'h17);
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rdchk(rows[i][18:16], rows[i][7:0]);
    end
    rdchk(3'h4, 8'h0F);
    chk(rdata14, 8'h0C);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h15);
    repeat (4) @(posedge mclk);
    chk({2'h0, pout}, 8'h15);
    rdchk(3'h0, 8'h1D);
    rdchk(3'h2, 8'h15);
    wr(3'h3, 8'h17);
    rdchk(3'h0, 8'h08);
    chk({2'h0, pout}, 8'h15);
    // Analog pins read 0, so the set loses the driven ones
    wr(3'h5, 8'h20);
    rdchk(3'h2, 8'h20);
    wr(3'h1, 8'h3F);
    wr(3'h3, 8'h00);
    ee <= 6'h3F;
    ev <= 6'h10;
    repeat (4) @(posedge mclk);
    chk({7'h0, tg}, 8'h01);
    rdchk(3'h0, 8'h10);
    wr(3'h4, 8'h08);
    repeat (3) @(posedge mclk);
    chk({7'h0, tg}, 8'h00);
    ev <= 6'h08;
    repeat (4) @(posedge mclk);
    chk({7'h0, tg}, 8'h01);
    ee <= 6'h00;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h00);
    ser_en <= 1'b1;
    ser <= 1'b1;
    pwm_en <= 1'b1;
    cc_en <= 1'b1;
    cc <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({2'h0, pout}, 8'h05);
    chk({2'h0, pout14}, 8'h00);
    chk({6'h0, c4_14, c4en14}, 8'h03);
    wr(3'h4, 8'h07);
    @(posedge mclk);
    chk({2'h0, pout}, 8'h30);
    chk({2'h0, pout14}, 8'h01);
    chk({6'h0, c4_14, c4en14}, 8'h01);
    ser_en <= 1'b0;
    pwm <= 1'b1;
    cc <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({2'h0, pout}, 8'h10);
    chk({7'h0, c4}, 8'h00);
    chk({7'h0, c4_en}, 8'h00);
    chk({6'h0, c4_14, c4en14}, 8'h03);
    pwm_en <= 1'b0;
    cc_en <= 1'b0;
    // Mid-run reset must restore direction and analog from any state
    rst_n <= 1'b0;
    @(posedge mclk);
    chk({2'h0, poe_n}, 8'h3F);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdchk(3'h3, 8'h17);
    rdchk(3'h1, 8'h3F);
    give_verdict();
  end
endmodule
`default_nettype wire
